// *** pcv_pkg.sv ***
// constants and types for the program counter sequencer
package pcv_pkg;
  localparam int PC_W        = 10;
  localparam int LO_W        = 8;
  localparam int HI_W        = PC_W - LO_W;
  localparam int STACK_DEPTH = 5;
  localparam int EVT_W       = 4;

  localparam logic [PC_W-1:0] RESET_VEC = 10'h000;
  localparam logic [PC_W-1:0] IRQ_VEC   = 10'h004;
  localparam logic [PC_W-1:0] PC_ONE    = 10'h001;
  localparam logic [LO_W-1:0] LO_ONE    = 8'h01;

  // apb register byte offsets
  localparam logic [7:0] ADDR_LATCH = 8'h00;
  localparam logic [7:0] ADDR_PC    = 8'h04;
  localparam logic [7:0] ADDR_WREG  = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_EVT   = 8'h10;
  localparam logic [7:0] ADDR_MASK  = 8'h14;

  // flag register bit positions
  localparam int FLAG_TO = 0;
  localparam int FLAG_PD = 1;

  // event bit positions
  localparam int EVT_RESTART = 0;
  localparam int EVT_IRQ     = 1;
  localparam int EVT_REFUSED = 2;
  localparam int EVT_WRAP    = 3;

  typedef enum logic [2:0] {
    OP_SEQ,
    OP_JUMP,
    OP_CALL,
    OP_RET,
    OP_ADD_LOW,
    OP_WR_LOW
  } pcv_op_e;

  // one completed instruction as reported by the core
  typedef struct packed {
    pcv_op_e         op;
    logic [PC_W-1:0] target;
    logic [LO_W-1:0] data;
  } pcv_instr_s;

  // apb request fields
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pcv_apb_s;
endpackage

// *** pcv_stack.sv ***
// five-entry return stack with wrap-around overflow
`timescale 1ns/1ps
`default_nettype none
module pcv_stack
  import pcv_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int W     = PC_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clear,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic              full
);
  localparam int SP_W  = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [SP_W-1:0]  SP_LAST = SP_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(DEPTH);

  logic [W-1:0]     mem [DEPTH];
  logic [SP_W-1:0]  sp_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [SP_W-1:0]  top_idx;

  // pointer to the next free slot, one above the top; overflow overwrites the oldest entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg  <= '0;
      cnt_reg <= '0;
    end else if (clear) begin
      sp_reg  <= '0;
      cnt_reg <= '0;
    end else if (push) begin
      sp_reg  <= (sp_reg == SP_LAST) ? '0 : sp_reg + SP_W'(1);
      cnt_reg <= (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + CNT_W'(1);
    end else if (pop) begin
      sp_reg  <= (sp_reg == '0) ? SP_LAST : sp_reg - SP_W'(1);
      cnt_reg <= (cnt_reg == '0) ? cnt_reg : cnt_reg - CNT_W'(1);
    end
  end

  // storage needs no reset, only the pointer and count do
  always_ff @(posedge pclk) begin
    if (push && !clear) begin
      mem[sp_reg] <= din;
    end
  end

  assign top_idx = (sp_reg == '0) ? SP_LAST : sp_reg - SP_W'(1);
  assign dout    = mem[top_idx];
  assign full    = (cnt_reg == CNT_MAX);
endmodule
`default_nettype wire

// *** pcv_core.sv ***
// program counter sequencer with reset, interrupt vectoring and apb registers
`timescale 1ns/1ps
`default_nettype none
module pcv_core
  import pcv_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  wdt_expire,
  input  wire logic                  low_voltage_reset,
  input  wire logic                  wdt_clear,
  input  wire logic                  sleep_enter,
  input  wire logic                  irq_accept,
  input  wire logic                  instr_valid,
  input  wire pcv_pkg::pcv_instr_s   instr,
  output logic      [pcv_pkg::PC_W-1:0] fetch_addr,
  output logic                       stack_full,
  output logic                       irq
);
  import pcv_pkg::*;

  pcv_apb_s        bus;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [HI_W-1:0] pc_high_latch_reg;
  logic [LO_W-1:0] working_register_reg;
  logic            timeout_flag_reg;
  logic            powerdown_flag_reg;
  logic [EVT_W-1:0] evt_reg;
  logic [EVT_W-1:0] evt_next;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] mask_reg;
  logic            restart;
  logic            irq_take;
  logic            irq_refused;
  logic            sw_pc_wr;
  logic            wr_fire;
  logic            rd_setup;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] stack_top;
  logic            full_w;
  logic            low_wrap;
  logic [LO_W:0]   add_sum;

  // join latch bits with a new low byte, no carry into the top
  function automatic logic [PC_W-1:0] pc_join(input logic [HI_W-1:0] hi,
                                              input logic [LO_W-1:0] lo);
    pc_join = {hi, lo};
  endfunction

  // decode of mapped offsets
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ADDR_LATCH) || (a == ADDR_PC) || (a == ADDR_WREG) ||
               (a == ADDR_FLAGS) || (a == ADDR_EVT) || (a == ADDR_MASK);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  assign bus      = '{psel: psel, penable: penable, pwrite: pwrite,
                      paddr: paddr, pwdata: pwdata};
  assign rd_setup = bus.psel && !bus.penable;
  assign wr_fire  = bus.psel && bus.penable && bus.pwrite && pready;
  assign sw_pc_wr = wr_fire && (bus.paddr == ADDR_PC);

  // both reset sources, watchdog and low voltage, share one restart path
  assign restart     = wdt_expire || low_voltage_reset;
  assign irq_take    = irq_accept && !full_w && !restart;
  assign irq_refused = irq_accept && full_w && !restart;

  //////////////////////////////////////////////////////////////////////////
  // next program counter; restart beats interrupt beats software beats core
  always_comb begin
    pc_next   = pc_reg;
    push      = 1'b0;
    pop       = 1'b0;
    push_data = pc_reg;
    low_wrap  = 1'b0;
    add_sum   = {1'b0, pc_reg[LO_W-1:0]} + {1'b0, working_register_reg};
    if (restart) begin
      pc_next = RESET_VEC;
    end else if (irq_take) begin
      push      = 1'b1;
      push_data = pc_reg;
      pc_next   = IRQ_VEC;
    end else if (sw_pc_wr) begin
      pc_next = pc_join(pc_high_latch_reg, bus.pwdata[LO_W-1:0]);
    end else if (instr_valid) begin
      unique case (instr.op)
        OP_SEQ: begin
          pc_next = pc_reg + PC_ONE;
        end
        OP_JUMP: begin
          pc_next = instr.target;
        end
        OP_CALL: begin
          push      = 1'b1;
          push_data = pc_reg + PC_ONE;
          pc_next   = instr.target;
        end
        OP_RET: begin
          pop     = 1'b1;
          pc_next = stack_top;
        end
        OP_ADD_LOW: begin
          // sum becomes the low byte, then steps by one
          low_wrap = add_sum[LO_W] || (add_sum[LO_W-1:0] == '1);
          pc_next  = pc_join(pc_high_latch_reg,
                             add_sum[LO_W-1:0] + LO_ONE);
        end
        OP_WR_LOW: begin
          low_wrap = (instr.data == '1);
          pc_next  = pc_join(pc_high_latch_reg, instr.data + LO_ONE);
        end
      endcase
    end
  end

  // program counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= RESET_VEC;
    end else begin
      pc_reg <= pc_next;
    end
  end

  assign fetch_addr = pc_reg;

  pcv_stack #(
    .DEPTH (DEPTH),
    .W     (PC_W)
  ) u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (restart),
    .push    (push),
    .pop     (pop),
    .din     (push_data),
    .dout    (stack_top),
    .full    (full_w)
  );

  // registered copy so the port comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_full <= 1'b0;
    end else begin
      stack_full <= full_w && !restart;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // latch and working register; never touched by interrupt entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_high_latch_reg    <= '0;
      working_register_reg <= '0;
    end else if (restart) begin
      pc_high_latch_reg    <= '0;
      working_register_reg <= '0;
    end else if (wr_fire) begin
      if (bus.paddr == ADDR_LATCH) begin
        pc_high_latch_reg <= bus.pwdata[HI_W-1:0];
      end
      if (bus.paddr == ADDR_WREG) begin
        working_register_reg <= bus.pwdata[LO_W-1:0];
      end
    end
  end

  // reset kind flags: watchdog clears timeout, sleep clears power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_reg   <= 1'b1;
      powerdown_flag_reg <= 1'b1;
    end else if (wdt_expire) begin
      timeout_flag_reg   <= 1'b0;
      powerdown_flag_reg <= 1'b1;
    end else if (low_voltage_reset || wdt_clear) begin
      timeout_flag_reg   <= 1'b1;
      powerdown_flag_reg <= 1'b1;
    end else if (sleep_enter) begin
      powerdown_flag_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear; a set in the same cycle wins
  always_comb begin
    evt_set = '0;
    evt_set[EVT_RESTART] = restart;
    evt_set[EVT_IRQ]     = irq_take;
    evt_set[EVT_REFUSED] = irq_refused;
    evt_set[EVT_WRAP]    = low_wrap && instr_valid && !restart && !irq_take &&
                           !sw_pc_wr;
    evt_next = evt_reg;
    if (wr_fire && (bus.paddr == ADDR_EVT)) begin
      evt_next = evt_reg & ~bus.pwdata[EVT_W-1:0];
    end
    evt_next = evt_next | evt_set;
  end

  // event, mask and interrupt line; events survive a restart so software sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg  <= '0;
      mask_reg <= '0;
      irq      <= 1'b0;
    end else begin
      evt_reg <= evt_next;
      if (wr_fire && (bus.paddr == ADDR_MASK)) begin
        mask_reg <= bus.pwdata[EVT_W-1:0];
      end
      irq <= |(evt_reg & mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, data captured in setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup && !addr_hit(bus.paddr);
      prdata  <= '0;
      if (rd_setup && !bus.pwrite) begin
        unique case (bus.paddr)
          ADDR_LATCH: prdata <= 32'(pc_high_latch_reg);
          ADDR_PC:    prdata <= 32'(pc_reg);
          ADDR_WREG:  prdata <= 32'(working_register_reg);
          ADDR_FLAGS: prdata <= 32'({powerdown_flag_reg, timeout_flag_reg});
          ADDR_EVT:   prdata <= 32'(evt_reg);
          ADDR_MASK:  prdata <= 32'(mask_reg);
          default:    prdata <= '0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_restart_vec;
    @(posedge pclk) disable iff (!presetn)
      restart |=> (pc_reg == RESET_VEC) && (pc_high_latch_reg == '0);
  endproperty
  a_restart_vec: assert property (p_restart_vec) else $error("restart not at zero");

  property p_lvr_same;
    @(posedge pclk) disable iff (!presetn)
      (low_voltage_reset && !wdt_expire) |=> (pc_reg == RESET_VEC) && timeout_flag_reg;
  endproperty
  a_lvr_same: assert property (p_lvr_same) else $error("low voltage restart differs");

  property p_wdt_flag;
    @(posedge pclk) disable iff (!presetn)
      wdt_expire |=> !timeout_flag_reg && powerdown_flag_reg;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flags wrong");

  property p_irq_vec;
    @(posedge pclk) disable iff (!presetn)
      irq_take |=> (pc_reg == IRQ_VEC) ##1 evt_reg[EVT_IRQ];
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("interrupt entry wrong");

  property p_irq_push;
    @(posedge pclk) disable iff (!presetn)
      irq_take |=> stack_top == $past(pc_reg);
  endproperty
  a_irq_push: assert property (p_irq_push) else $error("return address not pushed");

  property p_irq_keep;
    @(posedge pclk) disable iff (!presetn)
      irq_take |=> $stable(working_register_reg) && $stable(timeout_flag_reg);
  endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("context changed on entry");

  property p_add_low;
    @(posedge pclk) disable iff (!presetn)
      (instr_valid && instr.op == OP_ADD_LOW && !restart && !irq_take && !sw_pc_wr)
      |=> (pc_reg[LO_W-1:0] == LO_W'($past(pc_reg[LO_W-1:0]) +
           $past(working_register_reg) + LO_ONE)) &&
          (pc_reg[PC_W-1:LO_W] == $past(pc_high_latch_reg));
  endproperty
  a_add_low: assert property (p_add_low) else $error("computed jump wrong");

  property p_seq;
    @(posedge pclk) disable iff (!presetn)
      (instr_valid && instr.op == OP_SEQ && !restart && !irq_take && !sw_pc_wr)
      |=> pc_reg == PC_W'($past(pc_reg) + PC_ONE);
  endproperty
  a_seq: assert property (p_seq) else $error("sequential step wrong");

  property p_depth;
    @(posedge pclk) disable iff (!presetn)
      restart |=> !stack_full ##1 !full_w;
  endproperty
  a_depth: assert property (p_depth) else $error("stack not reset to top");
endmodule
`default_nettype wire

// *** pcv_rom_model.sv ***
// behavioural program memory that feeds words to the sequencer
`timescale 1ns/1ps
`default_nettype none
module pcv_rom_model (
  input  wire logic [pcv_pkg::PC_W-1:0] addr,
  output var  pcv_pkg::pcv_instr_s      data
);
  import pcv_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // 1k words; a 10-bit index cannot reach past the top word
  pcv_instr_s rom [1024];
  // blank words are plain sequential ops, so unwritten code just steps on
  initial begin
    for (int i = 0; i < 1024; i++) begin
      rom[i] = '{op: OP_SEQ, target: 10'h000, data: 8'h00};
    end
  end
  // always selected, so the word follows the address at once
  assign data = rom[addr];
endmodule
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the program counter sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcv_pkg::*;
  logic        pclk;
  logic        presetn;
  pcv_apb_s    bus;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [31:0] s;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        wdt_expire;
  logic        low_voltage_reset;
  logic        wdt_clear;
  logic        sleep_enter;
  logic        irq_accept;
  logic        instr_valid;
  pcv_instr_s  instr;
  logic [9:0]  fetch_addr;
  logic [9:0]  p;
  logic [9:0]  t;
  logic        stack_full;
  logic        irq;
  logic [7:0]  lo;
  logic [7:0]  w;
  logic [1:0]  hi;
  logic [9:0]  rets [$];
  int          fails;
  int          n_checks;
  int          cyc;

  ////////////////////////////////////////////////////////////////////////////
  // design and program memory
  pcv_rom_model mem (.addr(fetch_addr), .data(instr));
  pcv_core #(.DEPTH(STACK_DEPTH)) uut (
    .pclk(pclk), .presetn(presetn), .psel(bus.psel), .penable(bus.penable),
    .pwrite(bus.pwrite), .paddr(bus.paddr), .pwdata(bus.pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_expire(wdt_expire),
    .low_voltage_reset(low_voltage_reset), .wdt_clear(wdt_clear),
    .sleep_enter(sleep_enter), .irq_accept(irq_accept), .instr_valid(instr_valid),
    .instr(instr), .fetch_addr(fetch_addr), .stack_full(stack_full), .irq(irq)
  );

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // low byte wraps inside its own 8 bits, upper bits come from the latch
  function automatic logic [9:0] lo_next(input logic [1:0] h, input logic [7:0] b);
    return {h, b + 8'h01};
  endfunction

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task tdone(input string nm);
    $display("test %s done, checks %0d mismatches %0d", nm, n_checks, fails);
  endtask

  task final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // drivers; apb waits for pready instead of assuming the zero-wait answer
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    bus <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    bus.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    bus.psel <= 1'b0;
    bus.penable <= 1'b0;
    #1;
  endtask

  // one completed instruction, word placed in memory at the fetch address
  task exec(input pcv_op_e op, input logic [9:0] tg, input logic [7:0] dt);
    @(posedge pclk);
    mem.rom[fetch_addr] <= '{op: op, target: tg, data: dt};
    instr_valid <= 1'b1;
    @(posedge pclk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // one-cycle pulse on a side input
  task pulse(input int k);
    @(posedge pclk);
    wdt_expire <= (k == 0);
    low_voltage_reset <= (k == 1);
    wdt_clear <= (k == 2);
    sleep_enter <= (k == 3);
    irq_accept <= (k == 4);
    @(posedge pclk);
    {wdt_expire, low_voltage_reset, wdt_clear, sleep_enter, irq_accept} <= 5'h00;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    s = 32'hda4fad5f;
    {fails, n_checks, cyc} = '0;
    presetn = 1'b0;
    bus = '0;
    {wdt_expire, low_voltage_reset, wdt_clear, sleep_enter, irq_accept} = 5'h00;
    instr_valid = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("reset pc", 0, fetch_addr);
    apb(0, ADDR_FLAGS, 0);
    chk("reset flags", 3, q);
    chk("mapped err", 0, err);
    apb(0, 8'h18, 32'hffffffff);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, q);
    tdone("reset");
    // random jumps, each followed by one sequential step; first lands on the top word
    for (int i = 0; i < 6; i++) begin
      s = lfsr(s);
      t = (i == 0) ? 10'h3ff : s[9:0];
      exec(OP_JUMP, t, 8'h00);
      chk("jump", t, fetch_addr);
      exec(OP_SEQ, 10'h000, 8'h00);
      chk("seq", 10'(t + 10'h001), fetch_addr);
    end
    tdone("sequential");
    // computed jumps; the first pair overflows the low byte
    for (int i = 0; i < 6; i++) begin
      s = lfsr(s);
      hi = s[1:0];
      lo = (i == 0) ? 8'hfc : s[15:8];
      w = (i == 0) ? 8'h05 : s[23:16];
      apb(1, ADDR_LATCH, {s[31:2], hi});
      apb(0, ADDR_LATCH, 0);
      chk("latch", {30'h0, hi}, q);
      apb(1, ADDR_WREG, {s[31:8], w});
      exec(OP_JUMP, {~hi, lo}, 8'h00);
      exec(OP_ADD_LOW, 10'h000, 8'h00);
      chk("add low", lo_next(hi, lo + w), fetch_addr);
      exec(OP_WR_LOW, 10'h000, w);
      chk("write low", lo_next(hi, w), fetch_addr);
      apb(1, ADDR_PC, {24'h0, lo});
      chk("apb pc", {hi, lo}, fetch_addr);
    end
    chk("masked irq", 0, irq);
    apb(0, ADDR_EVT, 0);
    chk("wrap event", 32'h8, q & 32'h8);
    tdone("computed");
    // interrupt entry, event, mask, clear and return
    apb(1, ADDR_MASK, 32'h2);
    apb(1, ADDR_EVT, 32'hf);
    s = lfsr(s);
    p = s[9:0] | 10'h010;
    exec(OP_JUMP, p, 8'h00);
    pulse(4);
    chk("vector", IRQ_VEC, fetch_addr);
    repeat (3) @(posedge pclk);
    #1;
    chk("irq set", 1, irq);
    apb(0, ADDR_WREG, 0);
    chk("wreg kept", {24'h0, w}, q);
    apb(1, ADDR_EVT, 32'h2);
    repeat (2) @(posedge pclk);
    #1;
    chk("irq clear", 0, irq);
    exec(OP_RET, 10'h000, 8'h00);
    chk("irq return", p, fetch_addr);
    tdone("interrupt");
    // fill the stack, refuse an interrupt, unwind in reverse
    for (int i = 0; i < 5; i++) begin
      s = lfsr(s);
      rets.push_front(fetch_addr + 10'h001);
      exec(OP_CALL, s[9:0], 8'h00);
    end
    @(posedge pclk);
    #1;
    chk("full", 1, stack_full);
    p = fetch_addr;
    pulse(4);
    chk("refused", p, fetch_addr);
    apb(0, ADDR_EVT, 0);
    chk("refuse event", 32'h4, q & 32'h4);
    for (int i = 0; i < 5; i++) begin
      exec(OP_RET, 10'h000, 8'h00);
      chk("pop", rets[i], fetch_addr);
    end
    tdone("stack");
    // watchdog then low-voltage restart, then the flag pulses
    for (int k = 0; k < 2; k++) begin
      exec(OP_CALL, 10'h2aa, 8'h00);
      apb(1, ADDR_LATCH, 32'h3);
      pulse(k);
      chk("restart pc", 0, fetch_addr);
      apb(0, ADDR_FLAGS, 0);
      chk("restart flags", (k == 0) ? 2 : 3, q);
      apb(0, ADDR_LATCH, 0);
      chk("restart latch", 0, q);
    end
    apb(0, ADDR_EVT, 0);
    chk("restart event", 32'h1, q & 32'h1);
    pulse(3);
    apb(0, ADDR_FLAGS, 0);
    chk("sleep flags", 1, q);
    pulse(2);
    apb(0, ADDR_FLAGS, 0);
    chk("clear flags", 3, q);
    tdone("restart");
    final_report();
  end
endmodule
`default_nettype wire
